//--- src/panel_log_regs.vh
// Constants for the panel lamp and event log block
`ifndef PANEL_LOG_REGS_VH
`define PANEL_LOG_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_VIEW_IDX 12'h008
`define REG_VIEW_WORD 12'h00C
`define REG_PAGE 12'h010
`define REG_RTC 12'h014
// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define CTRL_PHASE_CHECK 0
`define CTRL_MODE_LSB 1
`define CTRL_RESET 32'h00000001
// ----------------------------------------
// Event types
// ----------------------------------------
`define EV_PERIODIC 4'h1
`define EV_CRANK 4'h2
`define EV_SHUTDOWN 4'h3
`define EV_LOADDUMP 4'h4
`define EV_WARNING 4'h5
`define EV_PROGRAM 4'h6
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 25000000
`define HOLD_S 10
`define PERIOD_RUN_MIN 60
`define PERIOD_ANY_MIN 120
`define FLASH_HALF_CYC 12500000
`define LOG_DEPTH 100
`define REC_WORDS 8
`endif

//--- src/panel_log.v
// Panel lamps, fault latch and circular event log with AHB-Lite registers
//
// Function
// - Utility ok lamp needs all checks good
// - Forced run request makes utility unavailable
// - Utility fail lamp on any bad check
// - Utility feed lamp follows utility contactor
// - Generator feed lamp follows generator contactor
// - Generator lamp flashes running, steady when good
// - Exactly one mode lamp lit, none in the dark unattended flash phase
// - Unattended lamp flashes when schedule forbids
// - Alarm steady on shutdown, flash on warning
// - First fault blocks lower or equal later
// - One lamp per detected condition
// - Keep the latest 100 records
// - Circular buffer overwrites the oldest
// - Viewer starts newest, steps older
// - Records stamped from clock, nonvolatile store (here plain registers; reset clears record count and pointer)
// - Record carries number, type, time, measurements
// - Periodic record 60 min running, 120 always
// - Record on crank engage
// - Record shutdown, loaddump, warning with category
// - Program entry record stores password level
// - Viewer opens after 10 s two-button hold
// - First page header, paging wraps around
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "panel_log_regs.vh"
module panel_log #(
  parameter integer CLK_HZ = `CLK_HZ,
  parameter integer HOLD_CYC = `HOLD_S * `CLK_HZ,
  parameter integer MIN_CYC = 60 * `CLK_HZ,
  parameter integer FLASH_CYC = `FLASH_HALF_CYC,
  parameter integer DEPTH = `LOG_DEPTH
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // AHB-Lite slave
  input wire hsel_in,
  input wire [11:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  // Supply and contactor status
  input wire util_volt_ok_in,
  input wire util_freq_ok_in,
  input wire util_rot_ok_in,
  input wire forced_run_request_in,
  input wire util_contactor_in,
  input wire gen_contactor_in,
  input wire engine_running_in,
  input wire [2:0] gen_volt_ok_in,
  input wire gen_freq_ok_in,
  input wire gen_rot_ok_in,
  input wire schedule_forbid_in,
  input wire crank_in,
  // Fault requests
  input wire shutdown_in,
  input wire loaddump_in,
  input wire warning_in,
  input wire fault_clear_in,
  input wire [6:0] cond_in,
  // Operator and program mode
  input wire btn_a_in,
  input wire btn_b_in,
  input wire btn_prev_in,
  input wire btn_page_in,
  input wire btn_exit_in,
  input wire prog_entry_in,
  input wire [1:0] pw_level_in,
  input wire [31:0] meas_in,
  // Lamps
  output reg util_ok_lamp_out,
  output reg util_fail_lamp_out,
  output reg util_feed_lamp_out,
  output reg gen_feed_lamp_out,
  output reg gen_lamp_out,
  output reg [3:0] mode_lamp_out,
  output reg alarm_lamp_out,
  output reg [6:0] cond_lamp_out,
  output reg viewer_open_out
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] ctrl_r; // Phase check and mode select
  reg [31:0] rtc_r; // Seconds counter as time stamp
  reg [31:0] sec_cnt_r; // Clock cycles within a second
  reg [31:0] min_cnt_r; // Seconds within a minute
  reg [6:0] run_min_r; // Running minutes
  reg [6:0] any_min_r; // Minutes regardless
  reg [31:0] flash_cnt_r; // Flash phase counter
  reg flash_r; // Flash phase
  reg [1:0] fault_lvl_r; // 0 none,1 warn,2 loaddump,3 shutdown
  reg crank_d_r; // Previous crank
  reg prog_d_r; // Previous program entry
  reg [31:0] log_mem [0:DEPTH*`REC_WORDS-1]; // Record store
  reg [6:0] wr_ptr_r; // Next slot
  reg [6:0] count_r; // Stored records
  reg [15:0] ev_num_r; // Event number
  reg [2:0] wr_word_r; // Word being written
  reg wr_busy_r; // Write in progress
  reg [31:0] wr_hdr_r; // Pending header
  reg [31:0] hold_cnt_r; // Button hold counter
  reg [6:0] view_r; // Records back from newest
  reg [2:0] page_r; // Page within record
  reg prev_d_r; // Previous page button
  reg pgb_d_r; // Previous prev button
  // Bus data phase state
  reg dp_valid_r;
  reg dp_write_r;
  reg [11:0] dp_addr_r;
  // ----------------------------------------
  // Combinational terms
  // ----------------------------------------
  wire [1:0] mode_w = ctrl_r[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
  wire rot_chk_w = ctrl_r[`CTRL_PHASE_CHECK];
  wire util_good_w = util_volt_ok_in & util_freq_ok_in & (util_rot_ok_in | ~rot_chk_w);
  wire gen_good_w = (&gen_volt_ok_in) & gen_freq_ok_in & (gen_rot_ok_in | ~rot_chk_w);
  wire min_tick_w = (sec_cnt_r == CLK_HZ - 1) && (min_cnt_r == 32'd59);
  wire per_run_w = min_tick_w && engine_running_in && (run_min_r == 7'd`PERIOD_RUN_MIN - 7'd1);
  wire per_any_w = min_tick_w && (any_min_r == 7'd`PERIOD_ANY_MIN - 7'd1);
  // Fault acceptance by priority
  wire acc_sd_w = shutdown_in && fault_lvl_r < 2'd3;
  wire acc_ld_w = loaddump_in && !shutdown_in && fault_lvl_r < 2'd2;
  wire acc_wn_w = warning_in && !shutdown_in && !loaddump_in && fault_lvl_r < 2'd1;
  reg ev_w;
  reg [3:0] ev_type_w;
  // Event source selection
  always @* begin
    ev_w = 1'b1;
    ev_type_w = `EV_PERIODIC;
    if (acc_sd_w) begin
      ev_type_w = `EV_SHUTDOWN;
    end else if (acc_ld_w) begin
      ev_type_w = `EV_LOADDUMP;
    end else if (acc_wn_w) begin
      ev_type_w = `EV_WARNING;
    end else if (crank_in && !crank_d_r) begin
      ev_type_w = `EV_CRANK;
    end else if (prog_entry_in && !prog_d_r) begin
      ev_type_w = `EV_PROGRAM;
    end else if (per_run_w || per_any_w) begin
      ev_type_w = `EV_PERIODIC;
    end else begin
      ev_w = 1'b0;
    end
  end
  // Selected record address for reading
  wire [6:0] newest_w = (wr_ptr_r == 7'd0) ? DEPTH[6:0] - 7'd1 : wr_ptr_r - 7'd1;
  wire [6:0] sel_w = (newest_w >= view_r) ? newest_w - view_r : newest_w + DEPTH[6:0] - view_r;
  wire [9:0] rd_addr_w = {sel_w, 3'b000} + {7'd0, page_r};
  wire [9:0] wr_addr_w = {wr_ptr_r, 3'b000} + {7'd0, wr_word_r};
  reg [31:0] wr_data_w;
  // Record word contents
  always @* begin
    case (wr_word_r)
      3'd0: wr_data_w = wr_hdr_r;
      3'd1: wr_data_w = rtc_r;
      3'd2: wr_data_w = {26'd0, mode_w, fault_lvl_r, engine_running_in, gen_contactor_in};
      default: wr_data_w = meas_in;
    endcase
  end
  // ----------------------------------------
  // Time base, flash and periodic counters
  // ----------------------------------------
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sec_cnt_r <= 32'd0;
      min_cnt_r <= 32'd0;
      rtc_r <= 32'd0;
      run_min_r <= 7'd0;
      any_min_r <= 7'd0;
      flash_cnt_r <= 32'd0;
      flash_r <= 1'b0;
    end else begin
      // Flash phase toggle
      if (flash_cnt_r == FLASH_CYC - 1) begin
        flash_cnt_r <= 32'd0;
        flash_r <= ~flash_r;
      end else begin
        flash_cnt_r <= flash_cnt_r + 32'd1;
      end
      if (sec_cnt_r == CLK_HZ - 1) begin
        sec_cnt_r <= 32'd0;
        rtc_r <= rtc_r + 32'd1;
        min_cnt_r <= (min_cnt_r == 32'd59) ? 32'd0 : min_cnt_r + 32'd1;
      end else begin
        sec_cnt_r <= sec_cnt_r + 32'd1;
      end
      if (min_tick_w) begin
        any_min_r <= per_any_w ? 7'd0 : any_min_r + 7'd1;
        if (engine_running_in) begin
          run_min_r <= per_run_w ? 7'd0 : run_min_r + 7'd1;
        end
      end
      if (!engine_running_in) begin
        run_min_r <= 7'd0;
      end
    end
  end
  // ----------------------------------------
  // Fault latch and event logging
  // ----------------------------------------
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_lvl_r <= 2'd0;
      crank_d_r <= 1'b0;
      prog_d_r <= 1'b0;
      wr_ptr_r <= 7'd0;
      count_r <= 7'd0;
      ev_num_r <= 16'd0;
      wr_word_r <= 3'd0;
      wr_busy_r <= 1'b0;
      wr_hdr_r <= 32'd0;
    end else begin
      crank_d_r <= crank_in;
      prog_d_r <= prog_entry_in;
      if (acc_sd_w) begin
        fault_lvl_r <= 2'd3;
      end else if (acc_ld_w) begin
        fault_lvl_r <= 2'd2;
      end else if (acc_wn_w) begin
        fault_lvl_r <= 2'd1;
      end else if (fault_clear_in) begin
        fault_lvl_r <= 2'd0;
      end
      // New event starts a record write when idle
      if (ev_w && !wr_busy_r) begin
        wr_busy_r <= 1'b1;
        wr_word_r <= 3'd0;
        ev_num_r <= ev_num_r + 16'd1;
        wr_hdr_r <= {ev_num_r + 16'd1, 6'd0, pw_level_in, 4'd0, ev_type_w};
      end else if (wr_busy_r) begin
        log_mem[wr_addr_w] <= wr_data_w;
        if (wr_word_r == `REC_WORDS - 1) begin
          // pointer moves only after last word
          wr_busy_r <= 1'b0;
          wr_ptr_r <= (wr_ptr_r == DEPTH[6:0] - 7'd1) ? 7'd0 : wr_ptr_r + 7'd1;
          if (count_r != DEPTH[6:0]) begin
            count_r <= count_r + 7'd1;
          end
        end else begin
          wr_word_r <= wr_word_r + 3'd1;
        end
      end
    end
  end
  // ----------------------------------------
  // Viewer
  // ----------------------------------------
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_cnt_r <= 32'd0;
      viewer_open_out <= 1'b0;
      view_r <= 7'd0;
      page_r <= 3'd0;
      prev_d_r <= 1'b0;
      pgb_d_r <= 1'b0;
    end else begin
      prev_d_r <= btn_page_in;
      pgb_d_r <= btn_prev_in;
      if (btn_a_in && btn_b_in) begin
        if (hold_cnt_r != HOLD_CYC) begin
          hold_cnt_r <= hold_cnt_r + 32'd1;
        end
      end else begin
        hold_cnt_r <= 32'd0;
      end
      if (!viewer_open_out && hold_cnt_r == HOLD_CYC - 1 && btn_a_in && btn_b_in) begin
        viewer_open_out <= 1'b1;
        view_r <= 7'd0;
        page_r <= 3'd0;
      end else if (viewer_open_out) begin
        if (btn_exit_in) begin
          viewer_open_out <= 1'b0;
        end else if (btn_prev_in && !pgb_d_r) begin
          if (count_r != 7'd0 && view_r != count_r - 7'd1) begin
            view_r <= view_r + 7'd1;
          end
          page_r <= 3'd0;
        end else if (btn_page_in && !prev_d_r) begin
          page_r <= (page_r == `REC_WORDS - 1) ? 3'd0 : page_r + 3'd1;
        end
      end
    end
  end
  // ----------------------------------------
  // Lamps
  // ----------------------------------------
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      util_ok_lamp_out <= 1'b0;
      util_fail_lamp_out <= 1'b0;
      util_feed_lamp_out <= 1'b0;
      gen_feed_lamp_out <= 1'b0;
      gen_lamp_out <= 1'b0;
      mode_lamp_out <= 4'h1;
      alarm_lamp_out <= 1'b0;
      cond_lamp_out <= 7'h00;
    end else begin
      util_ok_lamp_out <= util_good_w & ~forced_run_request_in;
      // utility fail lamp, also red under forced run
      util_fail_lamp_out <= ~util_good_w | forced_run_request_in;
      util_feed_lamp_out <= util_contactor_in;
      gen_feed_lamp_out <= gen_contactor_in;
      gen_lamp_out <= engine_running_in & (gen_good_w | flash_r);
      // one-hot mode, bit 1 is unattended
      mode_lamp_out <= 4'h1 << mode_w;
      if (mode_w == 2'd1 && schedule_forbid_in) begin
        mode_lamp_out <= {2'b00, flash_r, 1'b0};
      end
      alarm_lamp_out <= (fault_lvl_r >= 2'd2) | (fault_lvl_r == 2'd1 & flash_r);
      cond_lamp_out <= cond_in;
    end
  end
  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 12'h000;
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      ctrl_r <= `CTRL_RESET;
    end else begin
      if (hready_in) begin
        dp_valid_r <= hsel_in & htrans_in[1];
        dp_write_r <= hwrite_in;
        dp_addr_r <= haddr_in;
        // Read data presented in the data phase
        case (haddr_in)
          `REG_CTRL: hrdata_out <= ctrl_r;
          `REG_STATUS: hrdata_out <= {9'd0, count_r, 1'b0, wr_ptr_r, 4'd0, viewer_open_out, wr_busy_r, fault_lvl_r};
          `REG_VIEW_IDX: hrdata_out <= {25'd0, view_r};
          `REG_VIEW_WORD: hrdata_out <= (count_r != 7'd0) ? log_mem[rd_addr_w] : 32'h00000000;
          `REG_PAGE: hrdata_out <= {29'd0, page_r};
          `REG_RTC: hrdata_out <= rtc_r;
          default: hrdata_out <= 32'h00000000;
        endcase
      end
      // Write in data phase
      if (dp_valid_r && dp_write_r && dp_addr_r == `REG_CTRL) begin
        ctrl_r <= {29'd0, hwdata_in[2:0]};
      end
    end
  end
endmodule // panel_log

//--- test/panel_log_chk.sv
// Assertion checker for the panel lamp and event log block
`timescale 1ns/1ps
module panel_log_chk #(
  parameter integer HOLD_CYC = 20
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Status inputs
  input wire util_volt_ok_in,
  input wire util_freq_ok_in,
  input wire forced_run_request_in,
  input wire util_contactor_in,
  input wire gen_contactor_in,
  input wire engine_running_in,
  input wire [2:0] gen_volt_ok_in,
  input wire gen_freq_ok_in,
  input wire gen_rot_ok_in,
  input wire schedule_forbid_in,
  input wire [6:0] cond_in,
  input wire btn_a_in,
  input wire btn_b_in,
  // Lamps
  input wire util_ok_lamp_out,
  input wire util_fail_lamp_out,
  input wire util_feed_lamp_out,
  input wire gen_feed_lamp_out,
  input wire gen_lamp_out,
  input wire [3:0] mode_lamp_out,
  input wire [6:0] cond_lamp_out,
  input wire viewer_open_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Cycles both buttons held together
  reg [7:0] hold_r;
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) hold_r <= 8'h00;
    else if (btn_a_in && btn_b_in) hold_r <= (hold_r == 8'hFF) ? hold_r : hold_r + 8'h01;
    else hold_r <= 8'h00;
  end
  property p_ok; util_ok_lamp_out |-> $past(util_volt_ok_in && util_freq_ok_in && !forced_run_request_in); endproperty
  a_ok: assert property (p_ok) else $error("utility ok lamp without good supply");
  property p_frc; forced_run_request_in |=> !util_ok_lamp_out && util_fail_lamp_out; endproperty
  a_frc: assert property (p_frc) else $error("utility shown available under forced run");
  property p_fail; (!util_freq_ok_in)[*2] |=> util_fail_lamp_out; endproperty
  a_fail: assert property (p_fail) else $error("utility fail lamp dark on bad frequency");
  property p_uf; util_feed_lamp_out == $past(util_contactor_in); endproperty
  a_uf: assert property (p_uf) else $error("utility feed lamp off contactor");
  property p_gf; gen_feed_lamp_out == $past(gen_contactor_in); endproperty
  a_gf: assert property (p_gf) else $error("generator feed lamp off contactor");
  property p_gen; engine_running_in && (&gen_volt_ok_in) && gen_freq_ok_in && gen_rot_ok_in |=> gen_lamp_out; endproperty
  a_gen: assert property (p_gen) else $error("generator lamp not steady when good");
  // Unattended lamp may be in its dark flash phase while the schedule forbids running
  property p_mode; $onehot(mode_lamp_out) || ($past(schedule_forbid_in) && mode_lamp_out == 4'h0); endproperty
  a_mode: assert property (p_mode) else $error("mode lamps not one hot");
  property p_cond; cond_lamp_out == $past(cond_in); endproperty
  a_cond: assert property (p_cond) else $error("condition lamps off inputs");
  property p_view; $rose(viewer_open_out) |-> hold_r == HOLD_CYC; endproperty
  a_view: assert property (p_view) else $error("viewer opened on short hold");
endmodule // panel_log_chk
bind panel_log panel_log_chk #(.HOLD_CYC(HOLD_CYC)) panel_log_chk_inst (.*);

//--- test/panel_operator.sv
// Operator model pressing the panel buttons on command
`timescale 1ns/1ps
module panel_operator (
  // Clock and command
  input wire mclk_in,
  input wire [2:0] cmd_in,
  // Buttons, high while pressed
  output reg btn_a_out = 1'b0,
  output reg btn_b_out = 1'b0,
  output reg btn_prev_out = 1'b0,
  output reg btn_page_out = 1'b0,
  output reg btn_exit_out = 1'b0
);
  // Press the chosen buttons while the command stands
  always @(posedge mclk_in) begin
    btn_a_out <= (cmd_in == 3'h1);
    btn_b_out <= (cmd_in == 3'h1);
    btn_prev_out <= (cmd_in == 3'h2);
    btn_page_out <= (cmd_in == 3'h3);
    btn_exit_out <= (cmd_in == 3'h4);
  end
endmodule // panel_operator

//--- test/panel_log_tb.sv
// Self-checking bench for the panel lamp and event log block
`timescale 1ns/1ps
`include "panel_log_regs.vh"
module panel_log_tb;
  // Design pins
  logic mclk_in = 0, rst_in = 1, hsel_in = 0, hwrite_in = 0, hready_in, hreadyout_out, hresp_out;
  logic [11:0] haddr_in = 12'h000;
  logic [1:0] htrans_in = 2'h0, pw_level_in = 2'h2;
  logic [2:0] hsize_in = 3'h2, gen_volt_ok_in = 3'h0, cmd = 3'h0;
  logic [31:0] hwdata_in = 32'h0, meas_in = 32'h5A5AA5A5, hrdata_out, rd, t0;
  logic util_volt_ok_in = 0, util_freq_ok_in = 0, util_rot_ok_in = 0, forced_run_request_in = 0;
  logic util_contactor_in = 0, gen_contactor_in = 0, engine_running_in = 0, gen_freq_ok_in = 0;
  logic gen_rot_ok_in = 0, schedule_forbid_in = 0, crank_in = 0, shutdown_in = 0, loaddump_in = 0;
  logic warning_in = 0, fault_clear_in = 0, prog_entry_in = 0, alarm_lamp_out, viewer_open_out;
  logic btn_a_in, btn_b_in, btn_prev_in, btn_page_in, btn_exit_in, gen_lamp_out, v, f, r, fr;
  logic util_ok_lamp_out, util_fail_lamp_out, util_feed_lamp_out, gen_feed_lamp_out;
  logic [6:0] cond_in = 7'h00, cond_lamp_out;
  logic [3:0] mode_lamp_out;
  int n_fail = 0, checks = 0, ones;
  assign hready_in = hreadyout_out;
  panel_log #(.CLK_HZ(1), .HOLD_CYC(20), .FLASH_CYC(4)) panel_log_inst (.*);
  panel_operator panel_operator_inst (.mclk_in(mclk_in), .cmd_in(cmd), .btn_a_out(btn_a_in),
    .btn_b_out(btn_b_in), .btn_prev_out(btn_prev_in), .btn_page_out(btn_page_in), .btn_exit_out(btn_exit_in));
  always #20 mclk_in = ~mclk_in;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single AHB-Lite word transfer
  task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk_in);
    hsel_in <= 1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= wr;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
    hsel_in <= 0;
  endtask
  // Count lit cycles of one lamp over 16 cycles
  task lit(input int s, input int exp);
    repeat (3) @(posedge mclk_in);
    ones = 0;
    repeat (16) begin
      @(posedge mclk_in);
      #1 ones += (s == 0) ? gen_lamp_out : (s == 1) ? alarm_lamp_out : mode_lamp_out[1];
    end
    chk(ones, exp);
    @(posedge mclk_in);
  endtask
  task press(input logic [2:0] c, input int n);
    @(posedge mclk_in);
    cmd <= c;
    repeat (n) @(posedge mclk_in);
    cmd <= 3'h0;
    repeat (4) @(posedge mclk_in);
  endtask
  // Pulse one event or fault request
  task pulse(input int s);
    @(posedge mclk_in);
    case (s)
      0: crank_in <= 1;
      1: prog_entry_in <= 1;
      2: warning_in <= 1;
      3: shutdown_in <= 1;
      4: loaddump_in <= 1;
      default: fault_clear_in <= 1;
    endcase
    repeat (2) @(posedge mclk_in);
    {crank_in, prog_entry_in, warning_in, shutdown_in, loaddump_in, fault_clear_in} <= '0;
    repeat (12) @(posedge mclk_in);
  endtask
  task t_bus;
    chk(mode_lamp_out, 4'h1);
    ahb(0, `REG_CTRL, 0);
    chk(rd, `CTRL_RESET);
    ahb(0, 12'h0FC, 0);
    chk(rd, 32'h0);
    chk({hreadyout_out, hresp_out}, 2'h2);
    for (int m = 0; m < 4; m++) begin
      ahb(1, `REG_CTRL, (m << 1) | 1);
      repeat (2) @(posedge mclk_in);
      #1 chk(mode_lamp_out, 4'h1 << m);
    end
  endtask
  task t_util;
    for (int i = 0; i < 32; i++) begin
      if (i[3:0] == 0) ahb(1, `REG_CTRL, (i < 16) ? 32'h1 : 32'h0);
      @(posedge mclk_in);
      {fr, r, f, v} = i[3:0];
      {util_volt_ok_in, util_freq_ok_in, util_rot_ok_in, forced_run_request_in} <= {v, f, r, fr};
      {util_contactor_in, gen_contactor_in} <= {v, f};
      cond_in <= 7'h01 << (i % 7);
      repeat (2) @(posedge mclk_in);
      #1 chk(util_ok_lamp_out, v & f & (r | (i >= 16)) & !fr);
      chk(util_fail_lamp_out, !(v & f & (r | (i >= 16))) | fr);
      chk({util_feed_lamp_out, gen_feed_lamp_out}, {v, f});
      chk(cond_lamp_out, 7'h01 << (i % 7));
    end
  endtask
  task t_lamps;
    @(posedge mclk_in);
    engine_running_in <= 1;
    // Time stamp at engine start, base for the running period
    ahb(0, `REG_RTC, 0);
    t0 = rd;
    lit(0, 8);
    {gen_volt_ok_in, gen_freq_ok_in, gen_rot_ok_in} <= 5'h1F;
    lit(0, 16);
    gen_volt_ok_in <= 3'h6;
    lit(0, 8);
    ahb(1, `REG_CTRL, 32'h3);
    schedule_forbid_in <= 1;
    lit(2, 8);
    schedule_forbid_in <= 0;
    lit(2, 16);
  endtask
  task t_log;
    pulse(0);
    pulse(1);
    pulse(2);
    press(3'h1, 8);
    chk(viewer_open_out, 1'b0);
    press(3'h1, 24);
    chk(viewer_open_out, 1'b1);
    ahb(0, `REG_VIEW_WORD, 0);
    chk(rd & 32'h30F, 32'h205);
    press(3'h2, 2);
    ahb(0, `REG_VIEW_WORD, 0);
    chk(rd & 32'h30F, 32'h206);
    press(3'h2, 2);
    ahb(0, `REG_VIEW_WORD, 0);
    chk(rd & 32'h30F, 32'h202);
    repeat (3) press(3'h3, 2);
    ahb(0, `REG_VIEW_WORD, 0);
    chk(rd, 32'h5A5AA5A5);
    repeat (5) press(3'h3, 2);
    ahb(0, `REG_PAGE, 0);
    chk(rd, 32'h0);
    press(3'h4, 2);
    chk(viewer_open_out, 1'b0);
    for (int k = 0; k < 100; k++) pulse(0);
    ahb(0, `REG_STATUS, 0);
    chk(rd[22:16], 7'h64);
    chk(rd[14:8], 7'h03);
  endtask
  task t_alarm;
    pulse(5);
    pulse(2);
    lit(1, 8);
    pulse(3);
    lit(1, 16);
    pulse(2);
    pulse(4);
    ahb(0, `REG_STATUS, 0);
    chk(rd[1:0], 2'h3);
    pulse(5);
    pulse(4);
    pulse(4);
    pulse(2);
    ahb(0, `REG_STATUS, 0);
    chk(rd[1:0], 2'h2);
  endtask
  // Wait for the write pointer to reach p, then open the newest record
  task newest(input logic [6:0] p);
    int n;
    n = 0;
    do begin
      ahb(0, `REG_STATUS, 0);
      n++;
    end while (rd[14:8] !== p && n < 3000);
    chk(rd[14:8], p);
    press(3'h1, 24);
    ahb(0, `REG_VIEW_WORD, 0);
    chk(rd & 32'h30F, 32'h201);
    press(3'h3, 2);
    ahb(0, `REG_VIEW_WORD, 0);
    press(3'h4, 2);
  endtask
  // One second per cycle: 60 min running is 3600 cycles, 120 min is 7200
  task t_period;
    newest(7'd7);
    chk(rd - t0 >= 3530 && rd - t0 <= 3610, 1);
    newest(7'd8);
    chk(rd >= 7195 && rd <= 7210, 1);
  endtask
  task print_verdict;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_in <= 0;
    t_bus;
    t_util;
    t_lamps;
    t_log;
    t_alarm;
    t_period;
    print_verdict;
  end
  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge mclk_in);
    n_fail++;
    print_verdict;
  end
endmodule // panel_log_tb
